// ### inc/sml_pkg.sv
// package: constants, register map, states and carriers of the switch mac and lookup block
package sml_pkg;
  localparam int CLK_NS = 5;
  localparam int BIT_NS_100 = 10;
  localparam int BIT_NS_10 = 100;
  localparam logic [4:0] BIT_CYC_100 = 5'(BIT_NS_100 / CLK_NS);
  localparam logic [4:0] BIT_CYC_10 = 5'(BIT_NS_10 / CLK_NS);
  localparam logic [14:0] IPG_BITS = 15'd96;
  localparam logic [14:0] SLOT_BITS = 15'd512;
  localparam logic [14:0] BP_HOLD_BITS = 15'd20000;
  localparam logic [14:0] BP_SILENT_BITS = 15'd32;
  // free-running bit divider may shave up to one bit off a counted gap
  localparam int IPG_MIN_CYC = (96 - 1) * (BIT_NS_100 / CLK_NS);
  localparam logic [4:0] RETRY_LIMIT = 5'd16;
  localparam logic [3:0] BO_EXP_STD = 4'd10;
  localparam logic [3:0] BO_EXP_AGGR = 4'd3;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] PAUSE_MAX = 16'hffff;
  localparam logic [15:0] PAUSE_ZERO = 16'h0000;
  localparam logic [11:0] PAUSE_LEN = 12'd64;
  localparam logic [7:0] FC_HYST_CYC = 8'd64;
  localparam logic [11:0] MIN_LEN = 12'd64;
  localparam logic [11:0] MAX_STD = 12'd1518;
  localparam logic [11:0] MAX_MID = 12'd1536;
  localparam logic [11:0] MAX_JUMBO = 12'd2048;
  localparam logic [11:0] VLAN_ADD = 12'd4;
  localparam int STORM_MS_100 = 50;
  localparam int STORM_MS_10 = 500;
  localparam int AGE_S = 300;
  localparam int AGE_TOL_S = 75;
  localparam logic [1:0] AGE_LAST = 2'd3;
  localparam int TBL_DEPTH = 1024;
  localparam int TBL_AW = 10;
  localparam int NPORTS = 5;
  localparam logic [7:0] REG_CTRL_A = 8'h03;
  localparam logic [7:0] REG_CTRL_B = 8'h04;
  localparam logic [7:0] REG_RATE_A = 8'h06;
  localparam logic [7:0] REG_RATE_B = 8'h07;
  localparam logic [7:0] REG_PORT_CFG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h09;
  localparam int CA_AGGR = 0;
  localparam int CA_AGE_EN = 2;
  localparam int CA_JUMBO = 6;
  localparam int CB_ACC1536 = 1;
  localparam int CB_NO_EXC_DROP = 3;
  localparam int CB_BP_EN = 5;
  localparam int PC_STORM_EN = 0;
  localparam int PC_STORM_MC = 1;
  localparam logic [7:0] CTRL_A_RST = 8'h04;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h4a;
  localparam logic [7:0] PORT_CFG_RST = 8'h00;

  typedef struct packed {
    logic [11:0] len;
    logic err;
    logic vlan;
    logic pause;
    logic [15:0] pause_time;
    logic bcast;
    logic mcast;
    logic [47:0] sa;
    logic [47:0] da;
    logic [2:0] port;
  } sml_rx_frame_t;

  typedef struct packed {
    logic valid;
    logic drop;
    logic [NPORTS-1:0] map;
  } sml_fwd_t;

  typedef struct packed {
    logic is_pause;
    logic [15:0] pause_time;
    logic preamble;
    logic take;
    logic drop;
  } sml_tx_stat_t;

  typedef enum {T_IDLE, T_TX, T_BACKOFF, T_IPG, T_BP} sml_tx_st_t;
  typedef enum {L_IDLE, L_SCAN, L_DONE, L_AGE} sml_lu_st_t;
endpackage

// ### verilog/sml_mac_lookup.sv
// switch port mac control with shared address learning, aging and forwarding
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module sml_mac_lookup #(
  parameter longint unsigned STORM_CYC_100 = longint'(sml_pkg::STORM_MS_100) * 1000000 / 5,
  parameter longint unsigned STORM_CYC_10 = longint'(sml_pkg::STORM_MS_10) * 1000000 / 5,
  parameter longint unsigned AGE_TICK_CYC = longint'(sml_pkg::AGE_TOL_S) * 1000000000 / 5
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic MAC_CARRIER_INDICATION_I,
  input wire logic COLLISION_I,
  input wire logic SPEED100_I,
  input wire logic FULL_DUPLEX_I,
  input wire logic TX_REQ_I,
  input wire logic [11:0] TX_LEN_I,
  output logic MAC_TRANSMIT_STROBE_O,
  output sml_pkg::sml_tx_stat_t TX_STAT_O,
  input wire logic RX_VALID_I,
  input wire sml_pkg::sml_rx_frame_t RX_FRAME_I,
  output logic RX_READY_O,
  input wire logic DEST_BUSY_I,
  input wire logic RXQ_FULL_I,
  input wire logic [4:0] STAGE_MASK_I,
  input wire logic ACL_VALID_I,
  input wire logic [4:0] ACL_MAP_I,
  output logic [4:0] FIRST_STAGE_PORT_MAP_O,
  output sml_pkg::sml_fwd_t FINAL_FORWARD_PORT_MAP_O
);
  import sml_pkg::*;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  logic [3:0] pin_a, pin_b, pin_c, pin_f;
  logic crs, col, spd100, fdx, half;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_a <= '0;
      pin_b <= '0;
      pin_c <= '0;
      pin_f <= '0;
    end else begin
      pin_a <= {MAC_CARRIER_INDICATION_I, COLLISION_I, SPEED100_I, FULL_DUPLEX_I};
      pin_b <= pin_a;
      pin_c <= pin_b;
      pin_f <= (pin_b & pin_c) | (pin_f & ~(pin_b ^ pin_c));
    end
  end
  assign {crs, col, spd100, fdx} = pin_f;
  assign half = ~fdx;

  // register file
  logic [7:0] ctrl_a, ctrl_b, rate_a, rate_b, port_cfg, rd_byte, status;
  logic [7:0] idx;
  logic hit;
  assign idx = PADDR_I[9:2];
  always_comb begin
    hit = 1'b0;
    rd_byte = 8'h00;
    case (idx)
      REG_CTRL_A: begin hit = 1'b1; rd_byte = ctrl_a; end
      REG_CTRL_B: begin hit = 1'b1; rd_byte = ctrl_b; end
      REG_RATE_A: begin hit = 1'b1; rd_byte = rate_a; end
      REG_RATE_B: begin hit = 1'b1; rd_byte = rate_b; end
      REG_PORT_CFG: begin hit = 1'b1; rd_byte = port_cfg; end
      REG_STATUS: begin hit = 1'b1; rd_byte = status; end
      default: begin hit = 1'b0; rd_byte = 8'h00; end
    endcase
    if (PADDR_I[11:10] != 2'b00 || PADDR_I[1:0] != 2'b00) hit = 1'b0;
  end
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_a <= CTRL_A_RST;
      ctrl_b <= CTRL_B_RST;
      rate_a <= RATE_RST;
      rate_b <= RATE_RST;
      port_cfg <= PORT_CFG_RST;
      PRDATA_O <= 32'h0;
    end else begin
      if (PSEL_I && !PENABLE_I) PRDATA_O <= {24'h0, hit ? rd_byte : 8'h00};
      if (PSEL_I && PENABLE_I && PWRITE_I && hit) begin
        case (idx)
          REG_CTRL_A: ctrl_a <= PWDATA_I[7:0];
          REG_CTRL_B: ctrl_b <= PWDATA_I[7:0];
          REG_RATE_A: rate_a <= PWDATA_I[7:0];
          REG_RATE_B: rate_b <= PWDATA_I[7:0];
          REG_PORT_CFG: port_cfg <= PWDATA_I[7:0];
          default: ;
        endcase
      end
    end
  end

  // bit-time tick at the current line rate
  logic [4:0] bdiv, blim;
  logic btick;
  assign blim = spd100 ? BIT_CYC_100 : BIT_CYC_10;
  assign btick = bdiv >= blim - 5'd1;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) bdiv <= '0;
    else bdiv <= btick ? 5'd0 : bdiv + 5'd1;
  end

  // flow control trigger with release hysteresis
  logic fc_trig, fc_active, fc_rise, fc_fall, xoff_pend, xon_pend, start_ok, start_pause;
  logic [7:0] hyst;
  assign fc_trig = DEST_BUSY_I | RXQ_FULL_I;
  assign fc_rise = fc_trig & ~fc_active;
  assign fc_fall = fc_active & ~fc_trig & (hyst == FC_HYST_CYC - 8'd1);
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fc_active <= 1'b0;
      hyst <= '0;
      xoff_pend <= 1'b0;
      xon_pend <= 1'b0;
    end else begin
      if (fc_trig) begin
        fc_active <= 1'b1;
        hyst <= '0;
      end else if (fc_fall) begin
        fc_active <= 1'b0;
      end else if (fc_active) begin
        hyst <= hyst + 8'd1;
      end
      // a new request beats the send that would clear it
      xoff_pend <= (fc_rise & fdx) | (xoff_pend & ~fc_fall & ~start_pause);
      xon_pend <= (fc_fall & fdx) | (xon_pend & ~fc_rise & ~(start_pause & ~xoff_pend));
    end
  end

  // rx frame acceptance and legality
  logic rx_take, rx_good;
  logic [11:0] max_len;
  assign rx_take = RX_VALID_I & RX_READY_O;
  always_comb begin
    max_len = ctrl_a[CA_JUMBO] ? MAX_JUMBO : (ctrl_b[CB_ACC1536] ? MAX_MID : MAX_STD);
    if (RX_FRAME_I.vlan) max_len = max_len + VLAN_ADD;
    rx_good = !RX_FRAME_I.err && RX_FRAME_I.len >= MIN_LEN && RX_FRAME_I.len <= max_len;
  end

  // received pause timer
  logic [15:0] pause_q;
  logic [14:0] pq_bits;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pause_q <= '0;
      pq_bits <= '0;
    end else if (rx_take && RX_FRAME_I.pause && rx_good && fdx) begin
      pause_q <= RX_FRAME_I.pause_time;
      pq_bits <= '0;
    end else if (pause_q != 16'h0 && btick) begin
      if (pq_bits == SLOT_BITS - 15'd1) begin
        pq_bits <= '0;
        pause_q <= pause_q - 16'd1;
      end else begin
        pq_bits <= pq_bits + 15'd1;
      end
    end
  end

  // transmit sequencer
  sml_tx_st_t tx_st;
  logic [14:0] tbits, end_bits;
  logic [11:0] cur_len;
  logic [4:0] attempt, att1;
  logic [3:0] bo_cap, bo_exp;
  logic [9:0] bo_slots, bo_mask;
  logic [15:0] lfsr, cur_ptime;
  logic ipg_crs, bp_quiet, cur_pause, strobe_q, take_q, drop_q, bp_exit;
  assign end_bits = {cur_len, 3'b000} - 15'd1;
  assign att1 = attempt + 5'd1;
  assign bo_cap = ctrl_a[CA_AGGR] ? BO_EXP_AGGR : BO_EXP_STD;
  assign bo_exp = (att1 > {1'b0, bo_cap}) ? bo_cap : att1[3:0];
  assign bo_mask = 10'((11'd1 << bo_exp) - 11'd1);
  assign start_ok = tx_st == T_IDLE && !(half && crs);
  assign start_pause = start_ok & (xoff_pend | xon_pend);
  assign bp_exit = TX_REQ_I | ~fc_active | ~ctrl_b[CB_BP_EN] | fdx;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_st <= T_IDLE;
      tbits <= '0;
      cur_len <= '0;
      attempt <= '0;
      bo_slots <= '0;
      lfsr <= LFSR_SEED;
      cur_ptime <= PAUSE_ZERO;
      ipg_crs <= 1'b0;
      bp_quiet <= 1'b0;
      cur_pause <= 1'b0;
      strobe_q <= 1'b0;
      take_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      take_q <= 1'b0;
      drop_q <= 1'b0;
      case (tx_st)
        T_IDLE: begin
          tbits <= '0;
          if (start_pause) begin
            tx_st <= T_TX;
            strobe_q <= 1'b1;
            cur_pause <= 1'b1;
            cur_len <= PAUSE_LEN;
            cur_ptime <= xoff_pend ? PAUSE_MAX : PAUSE_ZERO;
          end else if (start_ok && TX_REQ_I && pause_q == 16'h0) begin
            tx_st <= T_TX;
            strobe_q <= 1'b1;
            cur_pause <= 1'b0;
            cur_len <= TX_LEN_I;
          end else if (start_ok && !bp_exit) begin
            tx_st <= T_BP;
            strobe_q <= 1'b1;
            bp_quiet <= 1'b0;
          end
        end
        T_TX: begin
          if (half && col) begin
            strobe_q <= 1'b0;
            ipg_crs <= 1'b1;
            tbits <= '0;
            if (tbits >= SLOT_BITS) begin
              take_q <= 1'b1;
              drop_q <= 1'b1;
              attempt <= '0;
              tx_st <= T_IPG;
            end else if (attempt == RETRY_LIMIT - 5'd1 && !ctrl_b[CB_NO_EXC_DROP]) begin
              take_q <= 1'b1;
              drop_q <= 1'b1;
              attempt <= '0;
              tx_st <= T_IPG;
            end else begin
              attempt <= (attempt == RETRY_LIMIT - 5'd1) ? 5'd0 : att1;
              bo_slots <= lfsr[9:0] & bo_mask;
              tx_st <= T_BACKOFF;
            end
          end else if (btick) begin
            if (tbits == end_bits) begin
              strobe_q <= 1'b0;
              take_q <= ~cur_pause;
              attempt <= '0;
              ipg_crs <= 1'b0;
              tbits <= '0;
              tx_st <= T_IPG;
            end else begin
              tbits <= tbits + 15'd1;
            end
          end
        end
        T_BACKOFF: begin
          if (bo_slots == 10'd0) begin
            tbits <= '0;
            tx_st <= T_IPG;
          end else if (btick) begin
            if (tbits == SLOT_BITS - 15'd1) begin
              tbits <= '0;
              bo_slots <= bo_slots - 10'd1;
            end else begin
              tbits <= tbits + 15'd1;
            end
          end
        end
        T_IPG: begin
          if (ipg_crs && crs) tbits <= '0;
          else if (btick) begin
            if (tbits == IPG_BITS - 15'd1) tx_st <= T_IDLE;
            else tbits <= tbits + 15'd1;
          end
        end
        T_BP: begin
          if (bp_exit) begin
            strobe_q <= 1'b0;
            ipg_crs <= 1'b0;
            tbits <= '0;
            tx_st <= T_IPG;
          end else if (col && bp_quiet) begin
            bp_quiet <= 1'b0;
            strobe_q <= 1'b1;
            tbits <= '0;
          end else if (btick) begin
            if (!bp_quiet && tbits == BP_HOLD_BITS - 15'd1) begin
              bp_quiet <= 1'b1;
              strobe_q <= 1'b0;
              tbits <= '0;
            end else if (bp_quiet && tbits == BP_SILENT_BITS - 15'd1) begin
              bp_quiet <= 1'b0;
              strobe_q <= 1'b1;
              tbits <= '0;
            end else begin
              tbits <= tbits + 15'd1;
            end
          end
        end
        default: tx_st <= T_IDLE;
      endcase
    end
  end
  assign MAC_TRANSMIT_STROBE_O = strobe_q;
  assign TX_STAT_O = '{cur_pause, cur_ptime, tx_st == T_BP, take_q, drop_q};

  // broadcast storm limiter
  logic [31:0] storm_tmr;
  logic [8:0] storm_cnt;
  logic [7:0] storm_lim;
  logic storm_tick, storm_frame, storm_over;
  assign storm_tick = storm_tmr >= 32'((spd100 ? STORM_CYC_100 : STORM_CYC_10) - 1);
  assign storm_lim = spd100 ? rate_b : rate_a;
  assign storm_frame = RX_FRAME_I.bcast | (port_cfg[PC_STORM_MC] & RX_FRAME_I.mcast);
  assign storm_over = port_cfg[PC_STORM_EN] && storm_cnt >= {1'b0, storm_lim};
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      storm_tmr <= '0;
      storm_cnt <= '0;
    end else begin
      storm_tmr <= storm_tick ? 32'd0 : storm_tmr + 32'd1;
      if (storm_tick) storm_cnt <= '0;
      else if (rx_take && storm_frame && !storm_over) storm_cnt <= storm_cnt + 9'd1;
    end
  end
  assign status = {attempt[3:0], tx_st == T_BP, fc_active, pause_q != 16'h0, storm_over};

  // address table and lookup engine
  logic [47:0] t_mac [TBL_DEPTH];
  logic [2:0] t_port [TBL_DEPTH];
  logic [1:0] t_age [TBL_DEPTH];
  logic [TBL_DEPTH-1:0] t_valid;
  sml_lu_st_t lu_st;
  sml_rx_frame_t lu_f;
  logic [TBL_AW-1:0] lidx, sa_idx, free_idx, widx;
  logic [2:0] da_port;
  logic lu_good, lu_storm, sa_hit, da_hit, free_ok, age_pend, age_take, learn;
  logic [39:0] age_tmr;
  logic [4:0] ing, first_map, fmap;
  logic fdrop;
  assign RX_READY_O = lu_st == L_IDLE && !age_pend;
  assign age_take = lu_st == L_IDLE && age_pend;
  assign learn = lu_st == L_DONE && lu_good;
  assign widx = sa_hit ? sa_idx : (free_ok ? free_idx : TBL_AW'(TBL_DEPTH - 1));
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lu_st <= L_IDLE;
      lu_f <= '0;
      lu_good <= 1'b0;
      lu_storm <= 1'b0;
      lidx <= '0;
      sa_idx <= '0;
      free_idx <= '0;
      da_port <= '0;
      sa_hit <= 1'b0;
      da_hit <= 1'b0;
      free_ok <= 1'b0;
      age_tmr <= '0;
      age_pend <= 1'b0;
      t_valid <= '0;
    end else begin
      age_tmr <= (age_tmr >= 40'(AGE_TICK_CYC - 1)) ? 40'd0 : age_tmr + 40'd1;
      age_pend <= (age_tmr >= 40'(AGE_TICK_CYC - 1)) | (age_pend & ~age_take);
      case (lu_st)
        L_IDLE: begin
          lidx <= '0;
          if (rx_take) begin
            lu_f <= RX_FRAME_I;
            lu_good <= rx_good;
            lu_storm <= storm_frame & storm_over;
            sa_hit <= 1'b0;
            da_hit <= 1'b0;
            free_ok <= 1'b0;
            lu_st <= L_SCAN;
          end else if (age_take && ctrl_a[CA_AGE_EN]) begin
            lu_st <= L_AGE;
          end
        end
        L_SCAN: begin
          if (t_valid[lidx] && t_mac[lidx] == lu_f.sa) begin
            sa_hit <= 1'b1;
            sa_idx <= lidx;
          end
          if (t_valid[lidx] && t_mac[lidx] == lu_f.da) begin
            da_hit <= 1'b1;
            da_port <= t_port[lidx];
          end
          if (!t_valid[lidx] && !free_ok) begin
            free_ok <= 1'b1;
            free_idx <= lidx;
          end
          if (lidx == TBL_AW'(TBL_DEPTH - 1)) lu_st <= L_DONE;
          else lidx <= lidx + 1'b1;
        end
        L_DONE: begin
          if (learn) t_valid[widx] <= 1'b1;
          lu_st <= L_IDLE;
        end
        L_AGE: begin
          if (t_valid[lidx] && t_age[lidx] == AGE_LAST) t_valid[lidx] <= 1'b0;
          if (lidx == TBL_AW'(TBL_DEPTH - 1)) lu_st <= L_IDLE;
          else lidx <= lidx + 1'b1;
        end
        default: lu_st <= L_IDLE;
      endcase
    end
  end

  // table contents carry no reset; the valid vector alone decides what is stored
  always_ff @(posedge REF_CLK_I) begin
    if (learn) begin
      t_mac[widx] <= lu_f.sa;
      t_port[widx] <= lu_f.port;
      t_age[widx] <= 2'd0;
    end else if (lu_st == L_AGE && t_valid[lidx] && t_age[lidx] != AGE_LAST) begin
      t_age[lidx] <= t_age[lidx] + 2'd1;
    end
  end

  always_comb begin
    ing = 5'(5'd1 << lu_f.port);
    first_map = (da_hit && !lu_f.bcast) ? 5'(5'd1 << da_port) : ~ing;
    fdrop = !lu_good || lu_f.pause || (da_hit && da_port == lu_f.port) || lu_storm;
    if (fdrop) fmap = 5'h00;
    else if (ACL_VALID_I) fmap = ACL_MAP_I;
    else fmap = first_map & STAGE_MASK_I & ~ing;
  end
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FIRST_STAGE_PORT_MAP_O <= '0;
      FINAL_FORWARD_PORT_MAP_O <= '0;
    end else begin
      FINAL_FORWARD_PORT_MAP_O.valid <= lu_st == L_DONE;
      if (lu_st == L_DONE) begin
        FIRST_STAGE_PORT_MAP_O <= first_map;
        FINAL_FORWARD_PORT_MAP_O.drop <= fdrop;
        FINAL_FORWARD_PORT_MAP_O.map <= fmap;
      end
    end
  end

  // checks
  logic [15:0] gap_cyc;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    // no frame before reset: the first frame owes no gap
    if (RST_I) gap_cyc <= 16'hffff;
    else if (strobe_q) gap_cyc <= '0;
    else if (gap_cyc != 16'hffff) gap_cyc <= gap_cyc + 16'd1;
  end
  sequence s_late;
    tx_st == T_TX && half && col && tbits >= SLOT_BITS;
  endsequence
  sequence s_xoff_start;
    start_pause && xoff_pend;
  endsequence
  property p_ipg;
    $rose(strobe_q) && tx_st == T_TX |-> gap_cyc >= 16'(IPG_MIN_CYC);
  endproperty
  a_ipg: assert property (p_ipg) else $error("transmit gap too short");
  property p_late;
    s_late |=> drop_q && take_q && tx_st == T_IPG;
  endproperty
  a_late: assert property (p_late) else $error("late collision not dropped");
  property p_retry;
    tx_st == T_TX && half && col && tbits < SLOT_BITS && attempt == 5'd15
      && !ctrl_b[CB_NO_EXC_DROP] |=> drop_q && attempt == 5'd0;
  endproperty
  a_retry: assert property (p_retry) else $error("16th collision not dropped");
  property p_pause_block;
    tx_st == T_IDLE && pause_q != 16'h0 |=> !(tx_st == T_TX && !cur_pause);
  endproperty
  a_pause_block: assert property (p_pause_block) else $error("sent while paused");
  property p_reload;
    rx_take && RX_FRAME_I.pause && rx_good && fdx |=> pause_q == $past(RX_FRAME_I.pause_time);
  endproperty
  a_reload: assert property (p_reload) else $error("pause timer not loaded");
  property p_xoff;
    s_xoff_start |=> tx_st == T_TX && cur_pause && cur_ptime == PAUSE_MAX && strobe_q;
  endproperty
  a_xoff: assert property (p_xoff) else $error("xoff without maximum time");
  property p_bp_col;
    tx_st == T_BP && col && !bp_exit |=> tx_st == T_BP && strobe_q;
  endproperty
  a_bp_col: assert property (p_bp_col) else $error("back pressure lost on collision");
  property p_short;
    rx_take && RX_FRAME_I.len < MIN_LEN |=> !lu_good ##1 lu_st == L_SCAN;
  endproperty
  a_short: assert property (p_short) else $error("runt frame marked good");
  property p_storm;
    storm_tick |=> storm_cnt == 9'd0;
  endproperty
  a_storm: assert property (p_storm) else $error("storm counter not cleared");
  property p_local;
    lu_st == L_DONE && da_hit && da_port == lu_f.port
      |=> FINAL_FORWARD_PORT_MAP_O.drop && FINAL_FORWARD_PORT_MAP_O.map == 5'h00;
  endproperty
  a_local: assert property (p_local) else $error("local frame forwarded");
endmodule

// ### testbench/sml_phy_model.sv
// phy model: carrier follows transmit, collision on demand
`timescale 1ns/1ps
module sml_phy_model (
  input wire logic clk_i,
  input wire logic tx_en_i,
  input wire logic coll_req_i,
  output logic crs_o = 1'b0,
  output logic col_o = 1'b0
);
  always_ff @(posedge clk_i) begin
    crs_o <= tx_en_i | coll_req_i;
    col_o <= tx_en_i & coll_req_i;
  end
endmodule

// ### testbench/switch_mac_and_address_lookup_test.sv
// testbench for the switch mac and lookup block
`timescale 1ns/1ps
module switch_mac_and_address_lookup_test;
  import sml_pkg::*;
  logic REF_CLK_I = 1'b0, RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = '0, TX_LEN_I = '0;
  logic [31:0] PWDATA_I = '0, PRDATA_O;
  logic PREADY_O, PSLVERR_O, crs, col, strb, RX_READY_O, RX_VALID_I = 1'b0;
  logic TX_REQ_I = 1'b0, DEST_BUSY_I = 1'b0, coll_req = 1'b0;
  sml_tx_stat_t TX_STAT_O;
  sml_rx_frame_t RX_FRAME_I = '0;
  sml_fwd_t fwd;
  logic fdx_pin = 1'b1, acl_valid = 1'b0;
  logic [4:0] acl_map = '0, fsm;
  int n_errors = 0, checks_done = 0, cyc = 0;
  always #2.5 REF_CLK_I = ~REF_CLK_I;
  sml_phy_model sml_phy_model_i (.clk_i(REF_CLK_I), .tx_en_i(strb), .coll_req_i(coll_req),
    .crs_o(crs), .col_o(col));
  sml_mac_lookup #(.STORM_CYC_100(2000), .STORM_CYC_10(4000), .AGE_TICK_CYC(5000))
  sml_mac_lookup_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .MAC_CARRIER_INDICATION_I(crs), .COLLISION_I(col), .SPEED100_I(1'b1),
    .FULL_DUPLEX_I(fdx_pin), .TX_REQ_I(TX_REQ_I), .TX_LEN_I(TX_LEN_I),
    .MAC_TRANSMIT_STROBE_O(strb), .TX_STAT_O(TX_STAT_O), .RX_VALID_I(RX_VALID_I),
    .RX_FRAME_I(RX_FRAME_I), .RX_READY_O(RX_READY_O), .DEST_BUSY_I(DEST_BUSY_I),
    .RXQ_FULL_I(1'b0), .STAGE_MASK_I(5'h1f), .ACL_VALID_I(acl_valid), .ACL_MAP_I(acl_map),
    .FIRST_STAGE_PORT_MAP_O(fsm), .FINAL_FORWARD_PORT_MAP_O(fwd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] q, output logic e);
    @(posedge REF_CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= {24'h0, d};
    @(posedge REF_CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge REF_CLK_I); while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask
  // waits for the transmit strobe to reach v, counting cycles
  task automatic wt(input logic v, output int n);
    n = 0;
    while (strb !== v && n < 5000) begin
      @(posedge REF_CLK_I);
      n++;
    end
    // a wait that ran out counts as a mismatch
    chk({31'h0, strb}, {31'h0, v});
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    logic [11:0] ad[4] = '{12'h00c, 12'h010, 12'h018, 12'h01c};
    logic [7:0] rv[4] = '{CTRL_A_RST, 8'h00, 8'h4a, 8'h4a};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ad[i], 8'h00, q, e);
      chk(q, {24'h0, rv[i]});
    end
    apb(1'b1, 12'h01c, 8'h10, q, e);
    apb(1'b0, 12'h01c, 8'h00, q, e);
    chk(q, 32'h10);
    apb(1'b0, 12'h028, 8'h00, q, e);
    chk({31'h0, e}, 32'h1);
    $display("register test done");
  endtask
  task automatic t_tx();
    int n;
    TX_LEN_I <= 12'd64;
    TX_REQ_I <= 1'b1;
    wt(1'b1, n);
    wt(1'b0, n);
    chk(32'(n >= 1022 && n <= 1026), 32'h1);
    // request still held: the second frame must wait out the gap
    wt(1'b1, n);
    chk(32'(n >= IPG_MIN_CYC), 32'h1);
    TX_REQ_I <= 1'b0;
    wt(1'b0, n);
    $display("transmit gap test done");
  endtask
  task automatic t_fc();
    int n;
    DEST_BUSY_I <= 1'b1;
    wt(1'b1, n);
    @(posedge REF_CLK_I);
    chk({31'h0, TX_STAT_O.is_pause}, 32'h1);
    chk({16'h0, TX_STAT_O.pause_time}, 32'hffff);
    DEST_BUSY_I <= 1'b0;
    wt(1'b0, n);
    wt(1'b1, n);
    @(posedge REF_CLK_I);
    chk({16'h0, TX_STAT_O.pause_time}, 32'h0);
    wt(1'b0, n);
    $display("flow control test done");
  endtask
  // half duplex: collision beyond one slot must end the frame as dropped
  task automatic t_late();
    int n;
    fdx_pin <= 1'b0;
    repeat (5) @(posedge REF_CLK_I);
    TX_LEN_I <= 12'd128;
    TX_REQ_I <= 1'b1;
    wt(1'b1, n);
    repeat (1100) @(posedge REF_CLK_I);
    coll_req <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK_I);
      n++;
    end while (TX_STAT_O.take !== 1'b1 && n < 100);
    chk({31'h0, TX_STAT_O.drop}, 32'h1);
    TX_REQ_I <= 1'b0;
    coll_req <= 1'b0;
    fdx_pin <= 1'b1;
    $display("late collision test done");
  endtask
  task automatic rx(input logic [11:0] len, input logic e, input logic p,
    input logic [2:0] pt, input logic [47:0] da, input logic d,
    input logic [4:0] m1, input logic [4:0] m2);
    sml_rx_frame_t f;
    int n;
    f = '0;
    f.len = len;
    f.err = e;
    f.pause = p;
    f.sa = 48'h0a;
    f.da = da;
    f.port = pt;
    RX_FRAME_I <= f;
    RX_VALID_I <= 1'b1;
    do @(posedge REF_CLK_I); while (RX_READY_O !== 1'b1);
    RX_VALID_I <= 1'b0;
    n = 0;
    do begin
      @(posedge REF_CLK_I);
      n++;
    end while (fwd.valid !== 1'b1 && n < 2000);
    chk({31'h0, fwd.valid}, 32'h1);
    chk({31'h0, fwd.drop}, {31'h0, d});
    chk({27'h0, fsm}, {27'h0, m1});
    chk({27'h0, fwd.map}, {27'h0, m2});
  endtask
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge REF_CLK_I);
    RST_I <= 1'b0;
    t_regs();
    t_tx();
    t_fc();
    t_late();
    rx(12'd64, 1'b0, 1'b0, 3'd1, 48'h0b, 1'b0, 5'h1d, 5'h1d);
    rx(12'd32, 1'b0, 1'b0, 3'd1, 48'h0b, 1'b1, 5'h1d, 5'h00);
    rx(12'd64, 1'b1, 1'b0, 3'd1, 48'h0b, 1'b1, 5'h1d, 5'h00);
    rx(12'd64, 1'b0, 1'b1, 3'd1, 48'h0b, 1'b1, 5'h1d, 5'h00);
    rx(12'd64, 1'b0, 1'b0, 3'd1, 48'h0a, 1'b1, 5'h02, 5'h00);
    // the station moves to port 2; a frame to it from port 1 is no longer local
    rx(12'd64, 1'b0, 1'b0, 3'd2, 48'h0b, 1'b0, 5'h1b, 5'h1b);
    acl_valid <= 1'b1;
    acl_map <= 5'h10;
    rx(12'd64, 1'b0, 1'b0, 3'd1, 48'h0a, 1'b0, 5'h04, 5'h10);
    acl_valid <= 1'b0;
    $display("receive test done");
    end_sim();
  end
endmodule
